// ---- core/cpu_status_core_control.sv ----
`timescale 1ns/1ps
`include "cpu_status_core_control_defines.svh"
module cpu_status_core_control (
    input  wire logic                                  hclk,
    input  wire logic                                  hresetn,
    input  wire logic                                  hsel,
    input  wire logic [7:0]                            haddr,
    input  wire cpu_status_core_control_pkg::htrans_type htrans,
    input  wire logic                                  hwrite,
    input  wire logic [2:0]                            hsize,
    input  wire logic [31:0]                           hwdata,
    input  wire logic                                  hready,
    output logic      [31:0]                           hrdata,
    output logic                                       hreadyout,
    output logic                                       hresp,
    input  wire logic                                  alu_update,
    input  wire logic                                  alu_subtract,
    input  wire logic                                  alu_byte_op,
    input  wire logic [15:0]                           alu_op_a,
    input  wire logic [15:0]                           alu_op_b,
    input  wire logic                                  alu_carry_in,
    input  wire logic                                  acc_update,
    input  wire logic                                  acc_a_guard_in,
    input  wire logic                                  acc_b_guard_in,
    input  wire logic                                  acc_a_clip_event,
    input  wire logic                                  acc_b_clip_event,
    input  wire logic                                  do_loop_start,
    input  wire logic                                  do_loop_end,
    input  wire logic                                  repeat_active_in,
    input  wire logic                                  nesting_disable,
    input  wire logic                                  prio_load,
    input  wire logic [3:0]                            prio_load_value,
    output logic                                       acc_a_clip_enable,
    output logic                                       acc_b_clip_enable,
    output logic                                       store_clip_enable,
    output logic                                       acc_clip_mode,
    output logic                                       dsp_mul_unsigned_sel,
    output logic                                       program_window_enable,
    output logic                                       rounding_mode_sel,
    output logic                                       dsp_int_mode,
    output logic                                       early_loop_exit,
    output logic      [3:0]                            cpu_priority_level,
    output logic                                       user_irq_block
);
    import cpu_status_core_control_pkg::*;

    // ****************************************
    // Bus address phase capture
    // ****************************************
    logic       wr_pend;
    logic [7:0] wr_addr;
    logic       rd_now;
    logic       wr_now;
    logic       acc_ok;

    assign acc_ok = hsel && hready && htrans == htrans_nseq_type_v;
    assign rd_now = acc_ok && !hwrite;
    assign wr_now = wr_pend;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= acc_ok && hwrite;
            wr_addr <= acc_ok ? haddr : wr_addr;
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    logic wr_flags;
    logic wr_mode;
    assign wr_flags = wr_now && wr_addr == `OFF_COND_FLAGS;
    assign wr_mode  = wr_now && wr_addr == `OFF_MODE_CTRL;

    // ****************************************
    // ALU flag computation
    // ****************************************
    logic [16:0] sum;
    logic [4:0]  nib_sum;
    logic [8:0]  byte_sum;
    logic [15:0] opb_eff;
    logic [15:0] res;
    logic        r_neg;
    logic        r_zero;
    logic        r_carry;
    logic        r_hc;
    logic        r_ovf;

    // Subtract adds complement; carry then means no borrow
    assign opb_eff  = alu_subtract ? ~alu_op_b : alu_op_b;
    assign sum      = {1'b0, alu_op_a} + {1'b0, opb_eff}
                    + {16'h0000, alu_carry_in};
    assign nib_sum  = {1'b0, alu_op_a[3:0]} + {1'b0, opb_eff[3:0]}
                    + {4'h0, alu_carry_in};
    assign byte_sum = {1'b0, alu_op_a[7:0]} + {1'b0, opb_eff[7:0]}
                    + {8'h00, alu_carry_in};
    assign res      = sum[15:0];
    assign r_hc     = alu_byte_op ? nib_sum[4] : byte_sum[8];
    assign r_carry  = alu_byte_op ? byte_sum[8] : sum[16];
    assign r_neg    = alu_byte_op ? res[7] : res[15];
    assign r_zero   = alu_byte_op ? res[7:0] == 8'h00
                                  : res == 16'h0000;
    assign r_ovf    = alu_byte_op
        ? (alu_op_a[7] == opb_eff[7]) && (res[7] != alu_op_a[7])
        : (alu_op_a[15] == opb_eff[15])
          && (res[15] != alu_op_a[15]);

    logic hc_f;
    logic neg_f;
    logic ovf_f;
    logic zero_f;
    logic carry_f;

    // Hardware update wins over a same-cycle software write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hc_f    <= 1'b0;
            neg_f   <= 1'b0;
            ovf_f   <= 1'b0;
            zero_f  <= 1'b0;
            carry_f <= 1'b0;
        end else if (alu_update) begin
            hc_f    <= r_hc;
            neg_f   <= r_neg;
            ovf_f   <= r_ovf;
            zero_f  <= r_zero;
            carry_f <= r_carry;
        end else if (wr_flags) begin
            hc_f    <= hwdata[`B_HCARRY];
            neg_f   <= hwdata[`B_NEG];
            ovf_f   <= hwdata[`B_OVF];
            zero_f  <= hwdata[`B_ZERO];
            carry_f <= hwdata[`B_CARRY];
        end
    end

    // ****************************************
    // Accumulator overflow and clip flags
    // ****************************************
    logic a_govf;
    logic b_govf;
    logic a_clip;
    logic b_clip;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_govf <= 1'b0;
            b_govf <= 1'b0;
        end else if (acc_update) begin
            a_govf <= acc_a_guard_in;
            b_govf <= acc_b_guard_in;
        end
    end

    logic clr_a;
    logic clr_b;
    // Clearing the combined bit clears both sticky bits
    assign clr_a = wr_flags && (!hwdata[`B_A_CLIP]
                 || !hwdata[`B_ANY_CLIP]);
    assign clr_b = wr_flags && (!hwdata[`B_B_CLIP]
                 || !hwdata[`B_ANY_CLIP]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_clip <= 1'b0;
            b_clip <= 1'b0;
        end else begin
            a_clip <= acc_a_clip_event || (a_clip && !clr_a);
            b_clip <= acc_b_clip_event || (b_clip && !clr_b);
        end
    end

    // ****************************************
    // Loop status
    // ****************************************
    logic [2:0] depth;
    logic       rep_act;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            depth <= 3'h0;
        end else if (do_loop_start && !do_loop_end && depth != 3'h7) begin
            depth <= depth + 3'h1;
        end else if (do_loop_end && !do_loop_start && depth != 3'h0) begin
            depth <= depth - 3'h1;
        end
    end

    // Pin level may be asynchronous to this block; not here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rep_act <= 1'b0;
        end else begin
            rep_act <= repeat_active_in;
        end
    end

    // ****************************************
    // Priority level
    // ****************************************
    prio3_type prio_lo;
    logic      prio_hi;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prio_lo <= 3'h0;
        end else if (prio_load) begin
            prio_lo <= prio_load_value[2:0];
        end else if (wr_flags && !nesting_disable) begin
            prio_lo <= hwdata[`B_PRIO_HI:`B_PRIO_LO];
        end
    end

    // High bit: software can only clear it; prio_load loads either value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prio_hi <= 1'b0;
        end else if (prio_load) begin
            prio_hi <= prio_load_value[3];
        end else if (wr_mode && !hwdata[`B_PRIO3]) begin
            prio_hi <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_priority_level <= 4'h0;
            user_irq_block     <= 1'b0;
        end else begin
            cpu_priority_level <= {prio_hi, prio_lo};
            user_irq_block     <= prio_hi
                                || prio_lo == `PRIO_BLOCK;
        end
    end

    // ****************************************
    // Mode control
    // ****************************************
    localparam reg16_type mode_rst = `RST_MODE_CTRL;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dsp_mul_unsigned_sel  <= mode_rst[`B_MUL_US];
            acc_a_clip_enable     <= mode_rst[`B_CLIP_A];
            acc_b_clip_enable     <= mode_rst[`B_CLIP_B];
            store_clip_enable     <= mode_rst[`B_CLIP_ST];
            acc_clip_mode         <= mode_rst[`B_CLIP_MD];
            program_window_enable <= mode_rst[`B_PROG_WIN];
            rounding_mode_sel     <= mode_rst[`B_RND];
            dsp_int_mode          <= mode_rst[`B_INT_MD];
        end else if (wr_mode) begin
            dsp_mul_unsigned_sel  <= hwdata[`B_MUL_US];
            acc_a_clip_enable     <= hwdata[`B_CLIP_A];
            acc_b_clip_enable     <= hwdata[`B_CLIP_B];
            store_clip_enable     <= hwdata[`B_CLIP_ST];
            acc_clip_mode         <= hwdata[`B_CLIP_MD];
            program_window_enable <= hwdata[`B_PROG_WIN];
            rounding_mode_sel     <= hwdata[`B_RND];
            dsp_int_mode          <= hwdata[`B_INT_MD];
        end
    end

    // One-cycle pulse; no storage so it always reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            early_loop_exit <= 1'b0;
        end else begin
            early_loop_exit <= wr_mode && hwdata[`B_EXIT];
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    reg16_type flags_rd;
    reg16_type mode_rd;
    logic [31:0] next_hrdata;

    always_comb begin
        flags_rd                        = 16'h0000;
        flags_rd[`B_A_GOVF]             = a_govf;
        flags_rd[`B_B_GOVF]             = b_govf;
        flags_rd[`B_A_CLIP]             = a_clip;
        flags_rd[`B_B_CLIP]             = b_clip;
        flags_rd[`B_ANY_GOVF]           = a_govf || b_govf;
        flags_rd[`B_ANY_CLIP]           = a_clip || b_clip;
        flags_rd[`B_DO_ACT]             = depth != 3'h0;
        flags_rd[`B_HCARRY]             = hc_f;
        flags_rd[`B_PRIO_HI:`B_PRIO_LO] = prio_lo;
        flags_rd[`B_REP_ACT]            = rep_act;
        flags_rd[`B_NEG]                = neg_f;
        flags_rd[`B_OVF]                = ovf_f;
        flags_rd[`B_ZERO]               = zero_f;
        flags_rd[`B_CARRY]              = carry_f;
        mode_rd                         = 16'h0000;
        mode_rd[`B_MUL_US]              = dsp_mul_unsigned_sel;
        mode_rd[`B_DEPTH_HI:`B_DEPTH_LO] = depth;
        mode_rd[`B_CLIP_A]              = acc_a_clip_enable;
        mode_rd[`B_CLIP_B]              = acc_b_clip_enable;
        mode_rd[`B_CLIP_ST]             = store_clip_enable;
        mode_rd[`B_CLIP_MD]             = acc_clip_mode;
        mode_rd[`B_PRIO3]               = prio_hi;
        mode_rd[`B_PROG_WIN]            = program_window_enable;
        mode_rd[`B_RND]                 = rounding_mode_sel;
        mode_rd[`B_INT_MD]              = dsp_int_mode;
        next_hrdata                     = 32'h0000_0000;
        case (haddr)
            `OFF_COND_FLAGS:  next_hrdata = {16'h0000, flags_rd};
            `OFF_MODE_CTRL:   next_hrdata = {16'h0000, mode_rd};
            `OFF_ALU_RESULT:  next_hrdata = {16'h0000, res};
            `OFF_LOOP_STATUS: next_hrdata = {28'h000_0000, rep_act,
                                             depth};
            default:          next_hrdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_now) begin
            hrdata <= next_hrdata;
        end
    end

endmodule // cpu_status_core_control

// ---- core/cpu_status_core_control_defines.svh ----
`ifndef CPU_STATUS_CORE_CONTROL_DEFINES_SVH
`define CPU_STATUS_CORE_CONTROL_DEFINES_SVH
// ********************
// Register byte offsets
// ********************
`define OFF_COND_FLAGS   8'h00
`define OFF_MODE_CTRL    8'h04
`define OFF_ALU_RESULT   8'h08
`define OFF_LOOP_STATUS  8'h0C
// ********************
// Condition flag positions
// ********************
`define B_A_GOVF   15
`define B_B_GOVF   14
`define B_A_CLIP   13
`define B_B_CLIP   12
`define B_ANY_GOVF 11
`define B_ANY_CLIP 10
`define B_DO_ACT   9
`define B_HCARRY   8
`define B_PRIO_HI  7
`define B_PRIO_LO  5
`define B_REP_ACT  4
`define B_NEG      3
`define B_OVF      2
`define B_ZERO     1
`define B_CARRY    0
// ********************
// Mode control positions
// ********************
`define B_MUL_US   12
`define B_EXIT     11
`define B_DEPTH_HI 10
`define B_DEPTH_LO 8
`define B_CLIP_A   7
`define B_CLIP_B   6
`define B_CLIP_ST  5
`define B_CLIP_MD  4
`define B_PRIO3    3
`define B_PROG_WIN 2
`define B_RND      1
`define B_INT_MD   0
// ********************
// Reset values and user interrupt block level
// ********************
`define RST_COND_FLAGS 16'h0000
`define RST_MODE_CTRL  16'h0020
`define PRIO_BLOCK     3'h7
`endif

// ---- core/cpu_status_core_control_pkg.sv ----
package cpu_status_core_control_pkg;
    typedef logic [15:0] reg16_type;
    typedef logic [2:0]  prio3_type;
    typedef enum logic [1:0] {
        htrans_idle_type_v = 2'h0,
        htrans_busy_type_v = 2'h1,
        htrans_nseq_type_v = 2'h2,
        htrans_seq_type_v  = 2'h3
    } htrans_type;
endpackage

// ---- tb/cpu_status_core_control_properties.sv ----
`timescale 1ns/1ps
module cpu_status_core_control_properties (
    input wire logic                                hclk,
    input wire logic                                hresetn,
    input wire logic                                hsel,
    input wire logic [7:0]                          haddr,
    input wire cpu_status_core_control_pkg::htrans_type htrans,
    input wire logic                                hwrite,
    input wire logic                                hready,
    input wire logic [31:0]                         hwdata,
    input wire logic [31:0]                         hrdata,
    input wire logic                                hreadyout,
    input wire logic                                prio_load,
    input wire logic [3:0]                          prio_load_value,
    input wire logic                                nesting_disable,
    input wire logic                                acc_a_clip_enable,
    input wire logic                                acc_b_clip_enable,
    input wire logic                                store_clip_enable,
    input wire logic                                acc_clip_mode,
    input wire logic                                dsp_mul_unsigned_sel,
    input wire logic                                program_window_enable,
    input wire logic                                rounding_mode_sel,
    input wire logic                                dsp_int_mode,
    input wire logic                                early_loop_exit,
    input wire logic [3:0]                          cpu_priority_level,
    input wire logic                                user_irq_block
);
    import cpu_status_core_control_pkg::*;
    // ********************
    // Data phase tracking
    // ********************
    logic       wr_dp;
    logic [7:0] wr_addr;
    logic       rd_take;
    logic       mode_wr;
    logic       exit_req;
    logic       lock_wr;
    logic [7:0] mode_bits;
    logic [7:0] wbits;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_dp   <= 1'b0;
            wr_addr <= 8'h00;
        end else if (hready) begin
            wr_dp   <= hsel && htrans == htrans_nseq_type_v && hwrite;
            wr_addr <= haddr;
        end
    end
    assign rd_take  = hsel && hready && htrans == htrans_nseq_type_v
                   && !hwrite;
    assign mode_wr  = wr_dp && wr_addr == 8'h04;
    assign exit_req = mode_wr && hwdata[11];
    // Hardware load wins, so only a quiet cycle proves the lock
    assign lock_wr  = wr_dp && wr_addr == 8'h00 && nesting_disable
                   && !prio_load;
    assign mode_bits = {dsp_mul_unsigned_sel, acc_a_clip_enable,
                        acc_b_clip_enable, store_clip_enable, acc_clip_mode,
                        program_window_enable, rounding_mode_sel, dsp_int_mode};
    assign wbits = {hwdata[12], hwdata[7:4], hwdata[2:0]};
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ********************
    // Properties
    // ********************
    a_mode_write_lands: assert property (
        mode_wr |=> mode_bits == $past(wbits))
        else $error("mode write lost");
    a_mode_holds_idle: assert property (
        !mode_wr |=> $stable(mode_bits))
        else $error("mode moved");
    a_exit_on_write: assert property (
        exit_req |=> early_loop_exit)
        else $error("no exit pulse");
    a_exit_only_write: assert property (
        early_loop_exit |-> $past(exit_req))
        else $error("stray exit pulse");
    a_prio_load_level: assert property (
        prio_load |-> ##2 cpu_priority_level == $past(prio_load_value, 2))
        else $error("level not loaded");
    a_block_level: assert property (
        user_irq_block ==
        (cpu_priority_level[3] || cpu_priority_level[2:0] == 3'h7))
        else $error("block wrong");
    a_prio_lock_holds: assert property (
        lock_wr |-> ##2
        cpu_priority_level[2:0] == $past(cpu_priority_level[2:0]))
        else $error("locked level moved");
    a_rd_unmapped_zero: assert property (
        rd_take && haddr >= 8'h10 |=> hrdata == 32'h0000_0000)
        else $error("unmapped not zero");
    a_rd_mode_zero: assert property (
        rd_take && haddr == 8'h04 |=>
        hrdata[31:13] == 19'h0_0000 && !hrdata[11])
        else $error("mode unused bits set");
    c_exit_req: cover property (exit_req);
    c_prio_load: cover property (prio_load ##2 user_irq_block);
    c_lock_wr: cover property (lock_wr);
    c_unmapped: cover property (rd_take && haddr >= 8'h10);
endmodule // cpu_status_core_control_properties

bind cpu_status_core_control cpu_status_core_control_properties i_props (.*);

// ---- tb/cpu_status_core_control_tb.sv ----
`timescale 1ns/1ps
module cpu_status_core_control_tb;
    import cpu_status_core_control_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
    logic [7:0]  haddr = 8'h00;
    htrans_type  htrans = htrans_idle_type_v;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        alu_update = 1'b0, alu_subtract = 1'b0, alu_byte_op = 1'b0;
    logic [15:0] alu_op_a = 16'h0000, alu_op_b = 16'h0000;
    logic        alu_carry_in = 1'b0, acc_update = 1'b0;
    logic        acc_a_guard_in = 1'b0, acc_b_guard_in = 1'b0;
    logic        acc_a_clip_event = 1'b0, acc_b_clip_event = 1'b0;
    logic        do_loop_start = 1'b0, do_loop_end = 1'b0;
    logic        repeat_active_in = 1'b0, nesting_disable = 1'b0;
    logic        prio_load = 1'b0;
    logic [3:0]  prio_load_value = 4'h0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, early_loop_exit, user_irq_block;
    logic        acc_a_clip_enable, acc_b_clip_enable, store_clip_enable;
    logic        acc_clip_mode, dsp_mul_unsigned_sel, program_window_enable;
    logic        rounding_mode_sel, dsp_int_mode;
    logic [3:0]  cpu_priority_level;
    logic [7:0]  mode_seen;
    logic [4:0]  prio_seen;
    int          num_errors = 0;
    int          total_checks = 0;
    assign mode_seen = {dsp_mul_unsigned_sel, acc_a_clip_enable,
                        acc_b_clip_enable, store_clip_enable, acc_clip_mode,
                        program_window_enable, rounding_mode_sel, dsp_int_mode};
    assign prio_seen = {user_irq_block, cpu_priority_level};
    cpu_status_core_control i_dut (
        .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .alu_update, .alu_subtract, .alu_byte_op, .alu_op_a, .alu_op_b,
        .alu_carry_in, .acc_update, .acc_a_guard_in, .acc_b_guard_in,
        .acc_a_clip_event, .acc_b_clip_event, .do_loop_start, .do_loop_end,
        .repeat_active_in, .nesting_disable, .prio_load, .prio_load_value,
        .acc_a_clip_enable, .acc_b_clip_enable, .store_clip_enable,
        .acc_clip_mode, .dsp_mul_unsigned_sel, .program_window_enable,
        .rounding_mode_sel, .dsp_int_mode, .early_loop_exit,
        .cpu_priority_level, .user_irq_block
    );
    always #20 hclk = ~hclk;
    // ********************
    // Bus and compare tasks
    // ********************
    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Not pipelined: each transfer ends before the next address phase
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        haddr  <= a;
        hwrite <= wr;
        htrans <= htrans_nseq_type_v;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= htrans_idle_type_v;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(name, exp, q);
    endtask
    // Packed as {subtract, byte, carry_in, op_a, op_b}
    function automatic logic [31:0] flags(input logic [34:0] v);
        logic [15:0] a, b;
        logic [16:0] w;
        logic [8:0]  lo;
        logic [4:0]  nb;
        logic        n, ov, z, c, dc;
        a  = v[31:16];
        b  = v[34] ? ~v[15:0] : v[15:0];
        w  = a + b + v[32];
        lo = a[7:0] + b[7:0] + v[32];
        nb = a[3:0] + b[3:0] + v[32];
        n  = v[33] ? lo[7] : w[15];
        z  = v[33] ? lo[7:0] == 8'h00 : w[15:0] == 16'h0000;
        c  = v[33] ? lo[8] : w[16];
        dc = v[33] ? nb[4] : lo[8];
        ov = v[33] ? (a[7] == b[7] && lo[7] != a[7])
                   : (a[15] == b[15] && w[15] != a[15]);
        return {23'h0, dc, 4'h0, n, ov, z, c};
    endfunction
    // ********************
    // Scenarios
    // ********************
    task automatic t_reset;
        rd_chk("flags reset", 8'h00, 32'h0000_0000);
        rd_chk("mode reset", 8'h04, 32'h0000_0020);
        check("store clip out", 32'h0000_0001, {31'h0, store_clip_enable});
        wr(8'h20, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'h20, 32'h0000_0000);
    endtask
    task automatic t_mode;
        wr(8'h04, 32'hFFFF_FFFF);
        #1;
        check("exit pulse", 32'h0000_0001, {31'h0, early_loop_exit});
        check("mode outs", 32'h0000_00FF, {24'h0, mode_seen});
        @(posedge hclk);
        rd_chk("mode ones", 8'h04, 32'h0000_10F7);
        wr(8'h04, 32'h0000_0000);
        rd_chk("mode zero", 8'h04, 32'h0000_0000);
    endtask
    task automatic t_clip;
        acc_a_clip_event <= 1'b1;
        @(posedge hclk);
        acc_a_clip_event <= 1'b0;
        rd_chk("clip a", 8'h00, 32'h0000_2400);
        wr(8'h00, 32'h0000_1400);
        rd_chk("clip a clr", 8'h00, 32'h0000_0000);
        wr(8'h00, 32'h0000_3400);
        rd_chk("clip no set", 8'h00, 32'h0000_0000);
        acc_a_clip_event <= 1'b1;
        acc_b_clip_event <= 1'b1;
        @(posedge hclk);
        acc_a_clip_event <= 1'b0;
        acc_b_clip_event <= 1'b0;
        rd_chk("clip both", 8'h00, 32'h0000_3400);
        wr(8'h00, 32'h0000_1400);
        rd_chk("clip b kept", 8'h00, 32'h0000_1400);
        wr(8'h00, 32'h0000_3000);
        rd_chk("clip all clr", 8'h00, 32'h0000_0000);
    endtask
    task automatic t_guard;
        logic [1:0] g;
        for (int i = 0; i < 3; i++) begin
            g = 2'b10 >> i;
            acc_a_guard_in <= g[1];
            acc_b_guard_in <= g[0];
            acc_update     <= 1'b1;
            @(posedge hclk);
            acc_update     <= 1'b0;
            rd_chk("guard", 8'h00, {16'h0, g, 2'b00, |g, 11'h0});
        end
        wr(8'h00, 32'h0000_C800);
        rd_chk("guard ro", 8'h00, 32'h0000_0000);
    endtask
    task automatic t_loop;
        do_loop_start <= 1'b1;
        repeat (9) @(posedge hclk);
        do_loop_start <= 1'b0;
        rd_chk("depth max", 8'h04, 32'h0000_0700);
        rd_chk("loop word", 8'h0C, 32'h0000_0007);
        rd_chk("do active", 8'h00, 32'h0000_0200);
        wr(8'h04, 32'h0000_0000);
        rd_chk("depth ro", 8'h04, 32'h0000_0700);
        do_loop_end <= 1'b1;
        repeat (7) @(posedge hclk);
        do_loop_end <= 1'b0;
        rd_chk("do idle", 8'h00, 32'h0000_0000);
        repeat_active_in <= 1'b1;
        @(posedge hclk);
        rd_chk("rep active", 8'h00, 32'h0000_0010);
        repeat_active_in <= 1'b0;
        @(posedge hclk);
        rd_chk("rep idle", 8'h00, 32'h0000_0000);
    endtask
    task automatic t_alu;
        logic [34:0] cs [6];
        cs = '{{3'b000, 16'h7FFF, 16'h0001}, {3'b000, 16'hFFFF, 16'h0001},
               {3'b101, 16'h0005, 16'h0005}, {3'b101, 16'h0003, 16'h0005},
               {3'b010, 16'h000F, 16'h0001}, {3'b010, 16'h0080, 16'h0080}};
        foreach (cs[i]) begin
            {alu_subtract, alu_byte_op, alu_carry_in, alu_op_a, alu_op_b} <= cs[i];
            alu_update <= 1'b1;
            @(posedge hclk);
            alu_update <= 1'b0;
            rd_chk("alu flags", 8'h00, flags(cs[i]));
        end
        rd_chk("alu result", 8'h08, 32'h0000_0100);
    endtask
    task automatic t_prio;
        wr(8'h00, 32'h0000_00E0);
        repeat (2) @(posedge hclk);
        check("level seven", 32'h0000_0017, {27'h0, prio_seen});
        wr(8'h00, 32'h0000_0040);
        repeat (2) @(posedge hclk);
        check("level two", 32'h0000_0002, {27'h0, prio_seen});
        nesting_disable <= 1'b1;
        wr(8'h00, 32'h0000_00A0);
        rd_chk("prio locked", 8'h00, 32'h0000_0040);
        prio_load_value <= 4'h9;
        prio_load       <= 1'b1;
        @(posedge hclk);
        prio_load       <= 1'b0;
        rd_chk("prio high", 8'h04, 32'h0000_0008);
        check("level nine", 32'h0000_0019, {27'h0, prio_seen});
        nesting_disable <= 1'b0;
        wr(8'h04, 32'h0000_0000);
        rd_chk("prio high clr", 8'h04, 32'h0000_0000);
    endtask
    // ********************
    // Sequence and verdict
    // ********************
    task automatic results;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_mode;
        t_clip;
        t_guard;
        t_loop;
        t_alu;
        t_prio;
        results;
    end
    // Whole run needs about 130 cycles
    initial begin
        repeat (3000) @(posedge hclk);
        num_errors++;
        results;
    end
endmodule // cpu_status_core_control_tb
